/* File: inc/sahc_pkg.sv */
// Types of the servo anti-hunt controller
package sahc_pkg;
	typedef enum logic [1:0] {
		SAHC_CLOSED   = 2'h0,
		SAHC_SETTLING = 2'h1,
		SAHC_OPEN     = 2'h3
	} sahc_state_type;
	typedef struct packed {
		logic        write;
		logic [15:0] open_thr;
		logic [15:0] close_thr;
	} sahc_thr_cmd_type;
	typedef struct packed {
		logic        write;
		logic [15:0] value;
	} sahc_word_cmd_type;
endpackage

/* File: inc/sahc_regs.svh */
// Constants of the servo anti-hunt controller
`ifndef SAHC_REGS_SVH
`define SAHC_REGS_SVH
`define SAHC_CLK_HZ          25000000
`define SAHC_TICK_NS         120000
`define SAHC_TICK_CYCLES     ((`SAHC_TICK_NS * (`SAHC_CLK_HZ / 1000000)) / 1000)
`define SAHC_DELAY_RESET     16'h04E2
`define SAHC_OPEN_THR_RESET  16'h000A
`define SAHC_CLOSE_THR_RESET 16'h0004
`define SAHC_THR_MAX         16'h008C
`define SAHC_MODE_STOPPED    1'h0
`define SAHC_MODE_MOVING     1'h1
`endif

/* File: tb/sahc_servo_model.sv */
// Servo loop and profiler model feeding the supervisor
module sahc_servo_model (
	// Settings from the bench
	input  wire logic               move_in,
	input  wire logic signed [15:0] err_in,
	input  wire logic [15:0]        torque_in,
	// Servo side outputs
	output logic                    in_motion_out,
	output logic signed [15:0]      pos_error_out,
	output logic [15:0]             torque_cmd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Plain levels, so no edge race with the bench
	assign in_motion_out  = move_in;
	assign pos_error_out  = err_in;
	assign torque_cmd_out = torque_in;
endmodule // sahc_servo_model

/* File: tb/sahc_testbench.sv */
// Self-checking bench for the anti-hunt supervisor
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                        clk_in, reset_in, move, mot, ol, db, md, ce;
	logic signed [15:0]          err, pe;
	logic [15:0]                 torque, tc;
	sahc_pkg::sahc_thr_cmd_type  thr, torque_limit_set;
	sahc_pkg::sahc_word_cmd_type dly, mde;
	int                          n_fail, tests_run, n;
	sahc_servo_model i_srv (.move_in(move), .err_in(err), .torque_in(torque),
		.in_motion_out(mot), .pos_error_out(pe), .torque_cmd_out(tc));
	sahc_core i_dut (.clk_in(clk_in), .reset_in(reset_in), .thr_cmd_in(thr),
		.delay_cmd_in(dly), .mode_cmd_in(mde), .torque_limit_set_in(torque_limit_set),
		.in_motion_in(mot), .pos_error_in(pe), .torque_cmd_in(tc),
		.open_loop_out(ol), .dead_band_out(db), .mode_out(md), .cmd_error_out(ce));
	// 25 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// One-cycle command pulse: 0 thr, 1 delay, 2 mode, 3 torque limits
	task automatic cmd(input int k, input logic [15:0] a, input logic [15:0] b);
		@(negedge clk_in);
		case (k)
			0: thr = '{1'b1, a, b};
			1: dly = '{1'b1, a};
			2: mde = '{1'b1, a};
			default: torque_limit_set = '{1'b1, a, b};
		endcase
		@(negedge clk_in);
		{thr.write, dly.write, mde.write, torque_limit_set.write} = 4'h0;
		@(negedge clk_in);
	endtask
	// Servo values change at the falling edge
	task automatic srv(input logic m, input logic [15:0] e, input logic [15:0] t);
		@(negedge clk_in);
		move = m;
		err = e;
		torque = t;
	endtask
	// Bounded wait for the loop state
	task automatic wo(input logic v, input int lim, output int c);
		c = 0;
		while (ol !== v && c < lim) begin
			@(negedge clk_in);
			c++;
		end
	endtask
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Watchdog well past the expected 20k cycles
	initial begin
		#2ms;
		n_fail++;
		complete_run;
	end
	// Main sequence
	initial begin
		{n_fail, tests_run, reset_in, move} = '0;
		{err, torque, thr, torque_limit_set, dly, mde} = '0;
		reset_in = 1'b1;
		err = 16'h0014;
		repeat (16) @(negedge clk_in);
		`CHK({ol, md, ce}, 3'h0)
		reset_in = 1'b0;
		repeat (2) @(negedge clk_in);
		`CHK(db, 1'h1)
		$display("Test reset done");
		// Dead band ignores torque; exit only past 10 counts
		cmd(1, 16'h0000, 16'h0000);
		srv(0, 16'h0003, 16'h0200);
		wo(1, 5, n); `CHK(ol, 1'h1)
		srv(0, 16'hFFF6, 16'h0200);
		repeat (4) @(negedge clk_in); `CHK(ol, 1'h1)
		srv(0, 16'hFFF5, 16'h0200);
		wo(0, 3, n); `CHK(ol, 1'h0)
		$display("Test thresholds done");
		// Motion in each mode, then a bad mode value
		srv(0, 16'h0003, 16'h0000);
		wo(1, 5, n);
		srv(1, 16'h0003, 16'h0000);
		wo(0, 3, n); `CHK(ol, 1'h0)
		cmd(1, 16'h0001, 16'h0000);
		cmd(2, 16'h0001, 16'h0000); `CHK(md, 1'h1)
		wo(1, 6100, n); `CHK(ol, 1'h1)
		cmd(2, 16'h0002, 16'h0000); `CHK({ce, md}, 2'h3)
		cmd(2, 16'h0000, 16'h0000); `CHK({ce, md}, 2'h0)
		wo(0, 3, n); `CHK(ol, 1'h0)
		$display("Test modes done");
		// Holding torque check, then negative entry limit skips it
		srv(0, 16'h0014, 16'h00C8);
		cmd(1, 16'h0000, 16'h0000);
		cmd(3, 16'h0032, 16'h0064); `CHK(db, 1'h0)
		srv(0, 16'h0003, 16'h00C8);
		wo(1, 50, n); `CHK(ol, 1'h0)
		srv(0, 16'h0003, 16'h0063);
		wo(1, 5, n); `CHK(ol, 1'h1)
		srv(0, 16'h0014, 16'h00C8);
		cmd(0, 16'h000A, 16'hFFFC);
		cmd(0, 16'h008D, 16'h0004);
		srv(0, 16'hFFFC, 16'h00C8);
		wo(1, 5, n); `CHK(ol, 1'h1)
		srv(0, 16'h000B, 16'h00C8);
		wo(0, 3, n); `CHK(ol, 1'h0)
		$display("Test torque done");
		// Two-tick settle, then a dropout restarts the count
		cmd(1, 16'h0002, 16'h0000);
		srv(0, 16'h0003, 16'h00C8);
		wo(1, 7000, n); `CHK(n > 2900 && n < 6010, 1'b1)
		srv(0, 16'h0014, 16'h00C8);
		srv(0, 16'h0003, 16'h00C8);
		repeat (4000) @(negedge clk_in);
		srv(0, 16'h0014, 16'h00C8);
		srv(0, 16'h0003, 16'h00C8);
		wo(1, 7000, n); `CHK(n > 2900 && n < 6010, 1'b1)
		$display("Test settle done");
		complete_run;
	end
endmodule // testbench

/* File: verilog/sahc_core.sv */
// Anti-hunt supervisor deciding open or closed position loop
// Notes on behaviour
// - Leave open loop when error exceeds exit threshold
// - Entry threshold is signed, -140 to 140
// - Non-negative entry: error at or below entry, torque below holding
// - Negative entry: skip torque check
// - Zero torque limits: thresholds form plain dead-band
// - Wait settling ticks of 120 us before entering
// - Mode 0: motion forces closed loop
// - Mode 1: ignore motion, error and torque checks govern
// - Mode 0 restores default; values above 1 rejected
`include "sahc_regs.svh"
module sahc_core (
	// Clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       reset_in,
	// Configuration commands
	input  wire sahc_pkg::sahc_thr_cmd_type  thr_cmd_in,
	input  wire sahc_pkg::sahc_word_cmd_type delay_cmd_in,
	input  wire sahc_pkg::sahc_word_cmd_type mode_cmd_in,
	input  wire sahc_pkg::sahc_thr_cmd_type  torque_limit_set_in,
	// Servo loop signals
	input  wire logic                       in_motion_in,
	input  wire logic signed [15:0]         pos_error_in,
	input  wire logic [15:0]                torque_cmd_in,
	// Status
	output logic                            open_loop_out,
	output logic                            dead_band_out,
	output logic                            mode_out,
	output logic                            cmd_error_out
);
	localparam int TICK_CYC = `SAHC_TICK_CYCLES;

	logic [15:0]             open_thr_q;
	logic signed [15:0]      close_thr_q;
	logic [15:0]             delay_q;
	logic                    mode_q;
	logic [15:0]             hold_tq_q;
	logic [15:0]             move_tq_q;
	logic [11:0]             tick_cnt_q;
	logic                    tick_q;
	logic [15:0]             settle_q;
	sahc_pkg::sahc_state_type state_q;
	logic                    cmd_err_q;
	logic                    dead_q;

	logic [15:0] abs_err;
	logic        entry_ok;
	logic        exit_hit;
	logic        thr_ok;
	logic        zero_tq;

	// Magnitude of error; most negative value gives 16'h8000, exact as unsigned
	assign abs_err  = pos_error_in[15] ? 16'(-pos_error_in) : pos_error_in;
	assign zero_tq  = (hold_tq_q == 16'h0000) && (move_tq_q == 16'h0000);
	// Negative entry limit compares against its magnitude
	assign thr_ok   = close_thr_q[15]
		? (abs_err <= 16'(-close_thr_q))
		: (abs_err <= 16'(close_thr_q));
	// Torque check only with non-negative limit and torque limits not both zero
	assign entry_ok = thr_ok
		&& (close_thr_q[15] || zero_tq || (torque_cmd_in < hold_tq_q))
		&& (mode_q == `SAHC_MODE_MOVING || !in_motion_in);
	assign exit_hit = (abs_err > open_thr_q)
		|| (mode_q == `SAHC_MODE_STOPPED && in_motion_in);

	// Threshold configuration; out-of-range writes rejected whole
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			open_thr_q  <= `SAHC_OPEN_THR_RESET;
			close_thr_q <= `SAHC_CLOSE_THR_RESET;
		end else if (thr_cmd_in.write
			&& !thr_cmd_in.open_thr[15] && thr_cmd_in.open_thr <= `SAHC_THR_MAX
			&& (thr_cmd_in.close_thr[15]
				? (16'(-thr_cmd_in.close_thr) <= `SAHC_THR_MAX)
				: (thr_cmd_in.close_thr <= `SAHC_THR_MAX))) begin
			open_thr_q  <= thr_cmd_in.open_thr;
			close_thr_q <= thr_cmd_in.close_thr;
		end
	end

	// Settling delay, any 16-bit value accepted
	always_ff @(posedge clk_in) begin
		if (reset_in)
			delay_q <= `SAHC_DELAY_RESET;
		else if (delay_cmd_in.write)
			delay_q <= delay_cmd_in.value;
	end

	// Mode; values other than 0 or 1 flag an error and keep mode
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mode_q    <= `SAHC_MODE_STOPPED;
			cmd_err_q <= 1'b0;
		end else if (mode_cmd_in.write) begin
			if (mode_cmd_in.value[15:1] == 15'h0000) begin
				mode_q    <= mode_cmd_in.value[0];
				cmd_err_q <= 1'b0;
			end else
				cmd_err_q <= 1'b1;
		end
	end

	// Torque limits from the limit command
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hold_tq_q <= 16'h0000;
			move_tq_q <= 16'h0000;
		end else if (torque_limit_set_in.write) begin
			hold_tq_q <= torque_limit_set_in.close_thr;
			move_tq_q <= torque_limit_set_in.open_thr;
		end
	end

	// Tick divider, 3000 clocks per 120 us
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tick_cnt_q <= 12'h000;
			tick_q     <= 1'b0;
		end else if (32'(tick_cnt_q) == TICK_CYC - 1) begin
			tick_cnt_q <= 12'h000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 12'h001;
			tick_q     <= 1'b0;
		end
	end

	// Loop state; settle count restarts if entry fails midway
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q  <= sahc_pkg::SAHC_CLOSED;
			settle_q <= 16'h0000;
		end else begin
			unique case (state_q)
				sahc_pkg::SAHC_CLOSED: begin
					settle_q <= 16'h0000;
					if (entry_ok)
						state_q <= (delay_q == 16'h0000) ? sahc_pkg::SAHC_OPEN
							: sahc_pkg::SAHC_SETTLING;
				end
				sahc_pkg::SAHC_SETTLING: begin
					if (!entry_ok) begin
						state_q  <= sahc_pkg::SAHC_CLOSED;
						settle_q <= 16'h0000;
					end else if (tick_q) begin
						if (settle_q + 16'h0001 >= delay_q)
							state_q <= sahc_pkg::SAHC_OPEN;
						settle_q <= settle_q + 16'h0001;
					end
				end
				sahc_pkg::SAHC_OPEN: begin
					settle_q <= 16'h0000;
					if (exit_hit)
						state_q <= sahc_pkg::SAHC_CLOSED;
				end
				default: state_q <= sahc_pkg::SAHC_CLOSED;
			endcase
		end
	end

	// Registered dead-band flag for zero torque limits
	always_ff @(posedge clk_in) begin
		if (reset_in)
			dead_q <= 1'b0;
		else
			dead_q <= zero_tq;
	end

	// Only the open code has bit 1 set, so the output is a plain flop bit
	assign open_loop_out = state_q[1];
	assign dead_band_out = dead_q;
	assign mode_out      = mode_q;
	assign cmd_error_out = cmd_err_q;

	// Checks
	property p_exit_on_error;
		@(posedge clk_in) disable iff (reset_in)
		(state_q == sahc_pkg::SAHC_OPEN && abs_err > open_thr_q)
			|=> state_q == sahc_pkg::SAHC_CLOSED;
	endproperty
	a_exit_on_error: assert property (p_exit_on_error) else $error("no exit on error");

	property p_motion_closes;
		@(posedge clk_in) disable iff (reset_in)
		(mode_q == 1'b0 && in_motion_in) |=> state_q != sahc_pkg::SAHC_OPEN;
	endproperty
	a_motion_closes: assert property (p_motion_closes) else $error("open while moving");

	property p_settle_restart;
		@(posedge clk_in) disable iff (reset_in)
		(state_q == sahc_pkg::SAHC_SETTLING && !entry_ok) |=> settle_q == 16'h0000;
	endproperty
	a_settle_restart: assert property (p_settle_restart) else $error("count kept");

	property p_open_needs_settle;
		@(posedge clk_in) disable iff (reset_in)
		($rose(open_loop_out) && $past(state_q) == sahc_pkg::SAHC_SETTLING)
			|-> $past(settle_q) + 16'h0001 >= $past(delay_q);
	endproperty
	a_open_needs_settle: assert property (p_open_needs_settle) else $error("early open");

	property p_bad_mode;
		@(posedge clk_in) disable iff (reset_in)
		(mode_cmd_in.write && mode_cmd_in.value[15:1] != 15'h0000)
			|=> cmd_error_out && mode_q == $past(mode_q);
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("bad mode taken");

	property p_tick_period;
		@(posedge clk_in) disable iff (reset_in)
		tick_q |=> !tick_q [*8];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick too fast");

	property p_enter_ok;
		@(posedge clk_in) disable iff (reset_in)
		(state_q == sahc_pkg::SAHC_CLOSED && !close_thr_q[15] && !zero_tq
			&& torque_cmd_in >= hold_tq_q) |=> state_q == sahc_pkg::SAHC_CLOSED;
	endproperty
	a_enter_ok: assert property (p_enter_ok) else $error("entry without cause");

	property p_neg_skip;
		@(posedge clk_in) disable iff (reset_in)
		(state_q == sahc_pkg::SAHC_CLOSED && close_thr_q[15] && !in_motion_in
			&& abs_err <= 16'(-close_thr_q)) |=> state_q != sahc_pkg::SAHC_CLOSED;
	endproperty
	a_neg_skip: assert property (p_neg_skip) else $error("torque checked");

	c_open: cover property (@(posedge clk_in) $rose(open_loop_out));
	c_exit: cover property (@(posedge clk_in) $fell(open_loop_out));
	c_restart: cover property (@(posedge clk_in)
		state_q == sahc_pkg::SAHC_SETTLING ##1 state_q == sahc_pkg::SAHC_CLOSED);
endmodule // sahc_core
